// ---- verilog/kpcfg_regs.svh ----
// Register offsets, reset values and timing counts of the keypad pin configuration block
`ifndef KPCFG_REGS_SVH
`define KPCFG_REGS_SVH
`define KPCFG_KSEL_ROWS   8'h1D
`define KPCFG_KSEL_COLS_L 8'h1E
`define KPCFG_KSEL_COLS_H 8'h1F
`define KPCFG_ELOG_ROWS   8'h20
`define KPCFG_ELOG_COLS_L 8'h21
`define KPCFG_ELOG_COLS_H 8'h23
`define KPCFG_DIR_ROWS    8'h23
`define KPCFG_DIR_COLS_L  8'h24
`define KPCFG_DIR_COLS_H  8'h25
`define KPCFG_POL_ROWS    8'h26
`define KPCFG_POL_COLS_L  8'h27
`define KPCFG_POL_COLS_H  8'h28
`define KPCFG_FOFF_ROWS   8'h29
`define KPCFG_FOFF_COLS_H 8'h2B
`define KPCFG_FOFF_COLS_L 8'h30
`define KPCFG_RESET_VALUE 18'h00000
`define KPCFG_CLK_PERIOD_NS 100
`define KPCFG_DEBOUNCE_NS 50000
`define KPCFG_DEBOUNCE_CYC ((`KPCFG_DEBOUNCE_NS + `KPCFG_CLK_PERIOD_NS - 1) / `KPCFG_CLK_PERIOD_NS)
`define KPCFG_SCAN_MS 25
`define KPCFG_SCAN_CYC (`KPCFG_SCAN_MS * 1000000 / `KPCFG_CLK_PERIOD_NS)
`define KPCFG_GPI_CODE_BASE 7'h61
`define KPCFG_KEY_CODE_BASE 7'h01
`endif

// ---- verilog/kpcfg_pkg.sv ----
// Types shared by the keypad pin configuration block
`default_nettype none
package kpcfg_pkg;
	// One bit per pin: bits 7..0 rows, bits 17..8 columns
	typedef logic [17:0] kpcfg_pins_type;
	// Event word for the shared event queue
	typedef struct packed {
		logic       press; // 1 = press or active level
		logic [6:0] code;  // Key or input code
	} kpcfg_event_type;
	// Column scanner states
	typedef enum logic {
		KPCFG_SCAN_IDLE = 1'b0,
		KPCFG_SCAN_RUN  = 1'b1
	} kpcfg_scan_type;
endpackage
`default_nettype wire

// ---- verilog/kpcfg_top.sv ----
// Keypad pin configuration, input debounce and column scan timing
//
// Behaviour
// - Select bit clear means general-purpose pin
// - Select bit set joins fixed row/column matrix
// - Event-logged inputs push changes into queue
// - Direction clear input, set output
// - Polarity clear triggers on falling/low
// - Polarity set triggers on rising/high
// - Filter-off bit bypasses input debounce
// - Bypass acts same on inputs and rows
// - Reset input always debounced 50 us
// - Input recognised after 50 us stable
// - All columns scanned every 25 ms
// - Key accepted after two matching scans
// - Input event codes 97 to 114
// - Enabled input change into trigger level sets change flag
`timescale 1ns/100ps
`default_nettype none
`include "kpcfg_regs.svh"
module kpcfg_top #(
	parameter int SCAN_CYCLES = `KPCFG_SCAN_CYC // Cycles per full column scan
) (
	input  wire logic                    sys_clk,           // 10 MHz clock
	input  wire logic                    rst_n,             // Async reset, active low
	input  wire logic [7:0]              reg_addr,          // Register offset
	input  wire logic [7:0]              reg_wdata,         // Write data
	input  wire logic                    reg_wr,            // Write strobe
	input  wire logic                    reg_rd,            // Read strobe
	output logic      [7:0]              reg_rdata,         // Read data, valid after reg_rd
	input  wire kpcfg_pkg::kpcfg_pins_type pin_in,          // Pin levels from pads
	output kpcfg_pkg::kpcfg_pins_type    pin_out,           // Pin drive levels
	output kpcfg_pkg::kpcfg_pins_type    pin_oe,            // Pin output enables
	input  wire kpcfg_pkg::kpcfg_pins_type gpio_data_out,   // Output data from data-out regs
	input  wire kpcfg_pkg::kpcfg_pins_type gpio_int_en,     // Interrupt enables per pin
	input  wire logic                    reset_pin_n,       // External reset pin, active low
	output logic                         reset_filtered_n,  // Debounced reset pin level
	output kpcfg_pkg::kpcfg_pins_type    gpi_level,         // Filtered input levels
	output logic                         ev_valid,          // Event word strobe
	output kpcfg_pkg::kpcfg_event_type   ev_word,           // Event word
	output logic                         input_change_flag, // Pulse: set status flag
	output kpcfg_pkg::kpcfg_pins_type    input_change_pins  // Pins causing the flag
);
	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam logic [8:0]  DEB_LAST  = 9'(`KPCFG_DEBOUNCE_CYC - 1); // Last stable count
	localparam logic [17:0] SLOT_LAST = 18'(SCAN_CYCLES / 10 - 1);   // Last cycle per column

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	kpcfg_pkg::kpcfg_pins_type keypad_select;    // 1 = matrix pin
	kpcfg_pkg::kpcfg_pins_type input_event_log;  // 1 = changes logged
	kpcfg_pkg::kpcfg_pins_type direction;        // 1 = output
	kpcfg_pkg::kpcfg_pins_type trigger_polarity; // 1 = rising/high
	kpcfg_pkg::kpcfg_pins_type filter_off;       // 1 = no debounce

	// Writes: offset 0x23 is shared, so one write lands in both registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			keypad_select    <= `KPCFG_RESET_VALUE;
			input_event_log  <= `KPCFG_RESET_VALUE;
			direction        <= `KPCFG_RESET_VALUE;
			trigger_polarity <= `KPCFG_RESET_VALUE;
			filter_off       <= `KPCFG_RESET_VALUE;
		end else if (reg_wr) begin
			case (reg_addr)
				`KPCFG_KSEL_ROWS:   keypad_select[7:0]    <= reg_wdata;
				`KPCFG_KSEL_COLS_L: keypad_select[15:8]   <= reg_wdata;
				`KPCFG_KSEL_COLS_H: keypad_select[17:16]  <= reg_wdata[1:0];
				`KPCFG_ELOG_ROWS:   input_event_log[7:0]  <= reg_wdata;
				`KPCFG_ELOG_COLS_L: input_event_log[15:8] <= reg_wdata;
				`KPCFG_DIR_ROWS: begin
					direction[7:0]         <= reg_wdata;
					input_event_log[17:16] <= reg_wdata[1:0];
				end
				`KPCFG_DIR_COLS_L:  direction[15:8]          <= reg_wdata;
				`KPCFG_DIR_COLS_H:  direction[17:16]         <= reg_wdata[1:0];
				`KPCFG_POL_ROWS:    trigger_polarity[7:0]    <= reg_wdata;
				`KPCFG_POL_COLS_L:  trigger_polarity[15:8]   <= reg_wdata;
				`KPCFG_POL_COLS_H:  trigger_polarity[17:16]  <= reg_wdata[1:0];
				`KPCFG_FOFF_ROWS:   filter_off[7:0]          <= reg_wdata;
				`KPCFG_FOFF_COLS_L: filter_off[15:8]         <= reg_wdata;
				`KPCFG_FOFF_COLS_H: filter_off[17:16]        <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// Byte lane of a pin vector; reserved high bits of lane 2 read zero
	function automatic logic [7:0] lane(input kpcfg_pkg::kpcfg_pins_type v, input int n);
		logic [7:0] b;
		b = 8'h00;
		case (n)
			0: b = v[7:0];
			1: b = v[15:8];
			default: b = {6'h00, v[17:16]};
		endcase
		return b;
	endfunction

	// Reads registered; unmapped offsets answer 0x00, 0x23 answers direction
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`KPCFG_KSEL_ROWS:   reg_rdata <= lane(keypad_select, 0);
				`KPCFG_KSEL_COLS_L: reg_rdata <= lane(keypad_select, 1);
				`KPCFG_KSEL_COLS_H: reg_rdata <= lane(keypad_select, 2);
				`KPCFG_ELOG_ROWS:   reg_rdata <= lane(input_event_log, 0);
				`KPCFG_ELOG_COLS_L: reg_rdata <= lane(input_event_log, 1);
				`KPCFG_DIR_ROWS:    reg_rdata <= lane(direction, 0);
				`KPCFG_DIR_COLS_L:  reg_rdata <= lane(direction, 1);
				`KPCFG_DIR_COLS_H:  reg_rdata <= lane(direction, 2);
				`KPCFG_POL_ROWS:    reg_rdata <= lane(trigger_polarity, 0);
				`KPCFG_POL_COLS_L:  reg_rdata <= lane(trigger_polarity, 1);
				`KPCFG_POL_COLS_H:  reg_rdata <= lane(trigger_polarity, 2);
				`KPCFG_FOFF_ROWS:   reg_rdata <= lane(filter_off, 0);
				`KPCFG_FOFF_COLS_L: reg_rdata <= lane(filter_off, 1);
				`KPCFG_FOFF_COLS_H: reg_rdata <= lane(filter_off, 2);
				default:            reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Synchronise and debounce: 18 pins plus the reset pin
	// ------------------------------------------------------------
	logic [18:0] raw_in;   // Pad levels, reset pin on top
	logic [18:0] bypass;   // Per channel debounce bypass
	logic [18:0] sync_a;   // First stage, read only by sync_b
	logic [18:0] sync_b;   // Second stage
	logic [18:0] stable;   // Debounced level
	logic [18:0] filtered; // Level used by the logic

	assign raw_in = {reset_pin_n, pin_in};
	assign bypass = {1'b0, filter_off};

	genvar gi;
	generate
		for (gi = 0; gi < 19; gi++) begin : g_chan
			logic [8:0] cnt; // Cycles the new level has held

			// Two flip-flops before any logic looks at the pad
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					sync_a[gi] <= 1'b1;
					sync_b[gi] <= 1'b1;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end

			// Any bounce restarts the count, so only a clean 50 us level passes
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					cnt        <= 9'h000;
					stable[gi] <= 1'b1;
				end else if (sync_b[gi] == stable[gi]) begin
					cnt <= 9'h000;
				end else if (cnt == DEB_LAST) begin
					stable[gi] <= sync_b[gi];
					cnt        <= 9'h000;
				end else begin
					cnt <= cnt + 9'h001;
				end
			end

			// Same bypass path for inputs and keypad rows
			assign filtered[gi] = bypass[gi] ? sync_b[gi] : stable[gi];
		end
	endgenerate

	// Filtered levels out, reset pin kept apart
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gpi_level        <= 18'h3FFFF;
			reset_filtered_n <= 1'b1;
		end else begin
			gpi_level        <= filtered[17:0];
			reset_filtered_n <= filtered[18];
		end
	end

	// ------------------------------------------------------------
	// Column scanner
	// ------------------------------------------------------------
	kpcfg_pkg::kpcfg_scan_type scan_state; // Idle until a column is selected; back to idle only after a full scan with none selected
	logic [17:0] slot_cnt;                  // Cycles within a column slot
	logic [3:0]  col_idx;                   // Column being driven
	logic [79:0] scan_now;                  // Samples of the scan in progress
	logic [79:0] scan_prev;                 // Previous full scan
	logic [79:0] key_down;                  // Accepted key state
	logic [79:0] next_scan;                 // scan_now with this slot merged
	logic [79:0] key_new;                   // Keys changing this cycle
	logic        slot_end;                  // Last cycle of a slot
	logic        scan_end;                  // Last slot of a full scan

	assign slot_end = (scan_state == kpcfg_pkg::KPCFG_SCAN_RUN) && (slot_cnt == SLOT_LAST);
	assign scan_end = slot_end && (col_idx == 4'h9);

	// Key k = row * 10 + column; pressed when a matrix row reads low
	always_comb begin
		next_scan = scan_now;
		key_new   = 80'h0;
		if (slot_end) begin
			for (int r = 0; r < 8; r++) begin
				next_scan[r * 10 + int'(col_idx)] = keypad_select[r]
					&& keypad_select[8 + int'(col_idx)] && !filtered[r];
			end
		end
		if (scan_end) begin
			key_new = (next_scan ~^ scan_prev) & (next_scan ^ key_down);
		end
	end

	// Slot timing: ten equal slots fill one scan period
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_state <= kpcfg_pkg::KPCFG_SCAN_IDLE;
			slot_cnt   <= 18'h00000;
			col_idx    <= 4'h0;
		end else begin
			unique case (scan_state)
				kpcfg_pkg::KPCFG_SCAN_IDLE: begin
					slot_cnt <= 18'h00000;
					col_idx  <= 4'h0;
					if (keypad_select[17:8] != 10'h000) begin
						scan_state <= kpcfg_pkg::KPCFG_SCAN_RUN;
					end
				end
				kpcfg_pkg::KPCFG_SCAN_RUN: begin
					if (slot_end) begin
						slot_cnt <= 18'h00000;
						col_idx  <= (col_idx == 4'h9) ? 4'h0 : col_idx + 4'h1;
						if (col_idx == 4'h9 && keypad_select[17:8] == 10'h000) begin
							scan_state <= kpcfg_pkg::KPCFG_SCAN_IDLE;
						end
					end else begin
						slot_cnt <= slot_cnt + 18'h00001;
					end
				end
			endcase
		end
	end

	// Scan images: a press needs the same answer in two full scans
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_now  <= 80'h0;
			scan_prev <= 80'h0;
			key_down  <= 80'h0;
		end else if (scan_end) begin
			scan_now  <= 80'h0;
			scan_prev <= next_scan;
			key_down  <= key_down ^ key_new;
		end else begin
			scan_now <= next_scan;
		end
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	// Active matrix column driven low, other matrix pins released, general-purpose pins per direction
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 18'h00000;
			pin_oe  <= 18'h00000;
		end else begin
			for (int p = 0; p < 18; p++) begin
				if (keypad_select[p]) begin
					pin_out[p] <= 1'b0;
					pin_oe[p]  <= (p >= 8) && (scan_state == kpcfg_pkg::KPCFG_SCAN_RUN)
						&& (p - 8 == int'(col_idx));
				end else begin
					pin_out[p] <= gpio_data_out[p];
					pin_oe[p]  <= direction[p];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// General-purpose input change detection
	// ------------------------------------------------------------
	kpcfg_pkg::kpcfg_pins_type level_prev; // Filtered level last cycle
	kpcfg_pkg::kpcfg_pins_type gpi_mask;   // Pins acting as inputs
	kpcfg_pkg::kpcfg_pins_type gpi_change; // Input changes this cycle
	kpcfg_pkg::kpcfg_pins_type gpi_hit;    // Changes into the trigger level

	assign gpi_mask   = ~keypad_select & ~direction;
	assign gpi_change = gpi_mask & (filtered[17:0] ^ level_prev);
	assign gpi_hit    = gpi_change & gpio_int_en & ~(filtered[17:0] ^ trigger_polarity);

	// Change flag pulses one cycle with the causing pins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_prev        <= 18'h3FFFF;
			input_change_flag <= 1'b0;
			input_change_pins <= 18'h00000;
		end else begin
			level_prev        <= filtered[17:0];
			input_change_flag <= |gpi_hit;
			input_change_pins <= gpi_hit;
		end
	end

	// ------------------------------------------------------------
	// Event arbiter
	// ------------------------------------------------------------
	logic [79:0]               key_pend; // Matrix events waiting
	kpcfg_pkg::kpcfg_pins_type gpi_pend; // Input events waiting
	logic [79:0]               key_gnt;  // Matrix event sent now
	kpcfg_pkg::kpcfg_pins_type gpi_gnt;  // Input event sent now
	kpcfg_pkg::kpcfg_event_type next_word; // Word to send

	// Lowest matrix key first, then lowest input; one word per cycle
	always_comb begin
		key_gnt   = 80'h0;
		gpi_gnt   = 18'h00000;
		next_word = '0;
		for (int g = 17; g >= 0; g--) begin
			if (gpi_pend[g]) begin
				gpi_gnt   = 18'h00000;
				gpi_gnt[g] = 1'b1;
				next_word.press = filtered[g] == trigger_polarity[g];
				next_word.code  = `KPCFG_GPI_CODE_BASE + 7'(g);
			end
		end
		for (int k = 79; k >= 0; k--) begin
			if (key_pend[k]) begin
				key_gnt    = 80'h0;
				key_gnt[k] = 1'b1;
				gpi_gnt    = 18'h00000;
				next_word.press = key_down[k];
				next_word.code  = `KPCFG_KEY_CODE_BASE + 7'(k);
			end
		end
	end

	// A new change wins over the grant that clears it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			key_pend <= 80'h0;
			gpi_pend <= 18'h00000;
		end else begin
			key_pend <= (key_pend & ~key_gnt) | key_new;
			gpi_pend <= (gpi_pend & ~gpi_gnt) | (gpi_change & input_event_log);
		end
	end

	// Registered event strobe
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_valid <= 1'b0;
			ev_word  <= '0;
		end else begin
			ev_valid <= (|key_pend) | (|gpi_pend);
			ev_word  <= next_word;
		end
	end
endmodule
`default_nettype wire

// ---- verification/kpcfg_asserts.sv ----
// Concurrent checks on the keypad pin configuration block ports
`timescale 1ns/100ps
`default_nettype none
module kpcfg_asserts (
	input wire logic                      sys_clk,           // Clock
	input wire logic                      rst_n,             // Reset, active low
	input wire logic [7:0]                reg_addr,          // Register offset
	input wire logic                      reg_rd,            // Read strobe
	input wire logic [7:0]                reg_rdata,         // Read data
	input wire kpcfg_pkg::kpcfg_pins_type gpio_int_en,       // Interrupt enables
	input wire logic                      reset_pin_n,       // Raw reset pin
	input wire logic                      reset_filtered_n,  // Filtered reset pin
	input wire logic                      ev_valid,          // Event strobe
	input wire kpcfg_pkg::kpcfg_event_type ev_word,          // Event word
	input wire logic                      input_change_flag, // Change pulse
	input wire kpcfg_pkg::kpcfg_pins_type input_change_pins  // Pins behind pulse
);
	// ----------------------------------------
	// Run lengths of the reset pin
	// ----------------------------------------
	logic [9:0] lo_cnt; // Consecutive low samples, saturating
	logic [9:0] hi_cnt; // Consecutive high samples, saturating
	// Counters saturate so a long hold never wraps into a false short run
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lo_cnt <= 10'h000;
			hi_cnt <= 10'h000;
		end else begin
			lo_cnt <= reset_pin_n ? 10'h000 : lo_cnt + {9'h000, ~&lo_cnt};
			hi_cnt <= reset_pin_n ? hi_cnt + {9'h000, ~&hi_cnt} : 10'h000;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Reads of the two-bit column bytes and of unmapped offsets
	sequence rd_hi;
		reg_rd && (reg_addr inside {8'h1F, 8'h25, 8'h28, 8'h2B});
	endsequence
	sequence rd_gap;
		reg_rd && (reg_addr inside {8'h22, 8'h2A});
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	hi_bits_a: assert property (rd_hi |=> reg_rdata[7:2] == 6'h00)
		else $error("unused column bits read nonzero");
	unmapped_read_a: assert property (rd_gap |=> reg_rdata == 8'h00)
		else $error("unmapped offset read nonzero");
	code_range_a: assert property (ev_valid |->
		ev_word.code inside {[7'h01:7'h50], [7'h61:7'h72]})
		else $error("event code out of range");
	flag_enable_a: assert property (input_change_flag |-> input_change_pins != 18'h00000
		&& (input_change_pins & ~$past(gpio_int_en)) == 18'h00000)
		else $error("change flag from disabled pin");
	flag_pulse_a: assert property (input_change_flag |=> !input_change_flag)
		else $error("change flag longer than one cycle");
	rst_fall_a: assert property ($fell(reset_filtered_n) |-> lo_cnt >= 10'h1F4)
		else $error("reset pin accepted low too early");
	rst_rise_a: assert property ($rose(reset_filtered_n) |-> hi_cnt >= 10'h1F4)
		else $error("reset pin accepted high too early");
endmodule
bind kpcfg_top kpcfg_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_int_en(gpio_int_en),
	.reset_pin_n(reset_pin_n), .reset_filtered_n(reset_filtered_n), .ev_valid(ev_valid),
	.ev_word(ev_word), .input_change_flag(input_change_flag),
	.input_change_pins(input_change_pins));
`default_nettype wire

// ---- verification/kpcfg_pads.sv ----
// Pad and keypad matrix model for the keypad pin configuration block
`timescale 1ns/100ps
`default_nettype none
module kpcfg_pads #(
	parameter int KEY_ROW = 3, // Row of the single modelled key
	parameter int KEY_COL = 0  // Column of that key
) (
	input wire kpcfg_pkg::kpcfg_pins_type pin_oe,   // Device drive enables
	input wire kpcfg_pkg::kpcfg_pins_type pin_out,  // Device drive levels
	input wire kpcfg_pkg::kpcfg_pins_type ext,      // Outside levels, 1 = pull-up
	input wire logic                      key_down, // Key held closed
	output kpcfg_pkg::kpcfg_pins_type     pin_in    // Resolved pad levels
);
	// Driven pins follow the device, released ones the outside level
	always_comb begin
		pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
		if (key_down && pin_oe[8 + KEY_COL] && !pin_out[8 + KEY_COL]) begin
			pin_in[KEY_ROW] = 1'b0; // Closed key pulls its row to the low column
		end
	end
endmodule
`default_nettype wire

// ---- verification/keypad_pin_config_and_debounce_test.sv ----
// Self-checking testbench of the keypad pin configuration block
`timescale 1ns/100ps
`default_nettype none
module keypad_pin_config_and_debounce_test;
	logic sys_clk, rst_n, reg_wr, reg_rd, reset_pin_n, reset_filtered_n;
	logic ev_valid, input_change_flag, key_down;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	kpcfg_pkg::kpcfg_pins_type pin_in, pin_out, pin_oe, gpio_data_out, gpio_int_en;
	kpcfg_pkg::kpcfg_pins_type gpi_level, input_change_pins, ext, flag_pins;
	kpcfg_pkg::kpcfg_event_type ev_word, ev_first;
	int n_mismatch, checked, ev_cnt, flag_cnt;
	logic [7:0] tbl [15] = '{8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h23, 8'h24, 8'h25,
		8'h26, 8'h27, 8'h28, 8'h29, 8'h2B, 8'h30, 8'h22};
	// ----------------------------------------
	// Design and pads
	// ----------------------------------------
	kpcfg_top #(.SCAN_CYCLES(100)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.gpio_data_out(gpio_data_out), .gpio_int_en(gpio_int_en),
		.reset_pin_n(reset_pin_n), .reset_filtered_n(reset_filtered_n),
		.gpi_level(gpi_level), .ev_valid(ev_valid), .ev_word(ev_word),
		.input_change_flag(input_change_flag), .input_change_pins(input_change_pins));
	kpcfg_pads #(.KEY_ROW(3), .KEY_COL(0)) pads (.pin_oe(pin_oe), .pin_out(pin_out),
		.ext(ext), .key_down(key_down), .pin_in(pin_in));
	// Clock, 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Event and flag monitor; single-cycle outputs are caught at the edge
	always @(posedge sys_clk) begin
		if (ev_valid === 1'b1) begin
			if (ev_cnt == 0) ev_first = ev_word;
			ev_cnt++;
		end
		if (input_change_flag === 1'b1) begin
			flag_cnt++;
			flag_pins = input_change_pins;
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
		checked++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			n_mismatch++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		chk("reg_rdata", {10'h000, e}, {10'h000, reg_rdata});
	endtask
	task automatic give_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog, well beyond the few thousand cycles the tests need
	initial begin
		#1000000;
		n_mismatch++;
		give_verdict();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, key_down, reg_addr, reg_wdata} = '0;
		{n_mismatch, checked, ev_cnt, flag_cnt} = '0;
		reset_pin_n = 1'b1;
		ext = 18'h3FFFF;
		gpio_data_out = 18'h00004;
		gpio_int_en = 18'h00000;
		cyc(8);
		rst_n = 1'b1;
		foreach (tbl[i]) rd(tbl[i], 8'h00);
		foreach (tbl[i]) wr(tbl[i], 8'hFF);
		foreach (tbl[i]) rd(tbl[i], (tbl[i] inside {8'h1F, 8'h25, 8'h28, 8'h2B}) ? 8'h03
			: (tbl[i] == 8'h22) ? 8'h00 : 8'hFF);
		foreach (tbl[i]) wr(tbl[i], 8'h00);
		cyc(600);
		// Pin 0 debounced, pin 1 bypassed with high trigger
		wr(8'h20, 8'h03);
		wr(8'h29, 8'h02);
		wr(8'h26, 8'h02);
		gpio_int_en = 18'h00003;
		ev_cnt = 0;
		flag_cnt = 0;
		ext[0] = 1'b0;
		cyc(400);
		chk("gpi_level", 18'h3FFFF, gpi_level);
		cyc(120);
		chk("gpi_level", 18'h3FFFE, gpi_level);
		chk("ev_word", 18'h000E1, {10'h000, ev_first});
		chk("flag_pins", 18'h00001, flag_pins);
		ext[1] = 1'b0;
		cyc(5);
		chk("gpi_level", 18'h3FFFC, gpi_level);
		chk("flag_cnt", 18'h00001, flag_cnt[17:0]);
		ext[1] = 1'b1;
		cyc(5);
		chk("flag_pins", 18'h00002, flag_pins);
		chk("ev_cnt", 18'h00003, ev_cnt[17:0]);
		// Pin 2 as output
		wr(8'h23, 8'h04);
		cyc(3);
		chk("pin_oe", 18'h00004, pin_oe);
		chk("pin_out", 18'h00001, {17'h00000, pin_out[2]});
		// Reset pin filter, short pulse refused
		reset_pin_n = 1'b0;
		cyc(300);
		chk("reset_filtered_n", 18'h00001, {17'h00000, reset_filtered_n});
		reset_pin_n = 1'b1;
		cyc(10);
		reset_pin_n = 1'b0;
		cyc(520);
		chk("reset_filtered_n", 18'h00000, {17'h00000, reset_filtered_n});
		reset_pin_n = 1'b1;
		cyc(520);
		chk("reset_filtered_n", 18'h00001, {17'h00000, reset_filtered_n});
		// Key at row 3, column 0, row filter bypassed
		wr(8'h29, 8'h0A);
		wr(8'h1D, 8'h08);
		wr(8'h1E, 8'h01);
		ev_cnt = 0;
		key_down = 1'b1;
		cyc(95);
		chk("ev_cnt", 18'h00000, ev_cnt[17:0]);
		cyc(305);
		chk("ev_word", 18'h0009F, {10'h000, ev_first});
		// Release also needs two matching scans, then a release word
		ev_cnt = 0;
		key_down = 1'b0;
		cyc(300);
		chk("ev_word", 18'h0001F, {10'h000, ev_first});
		give_verdict();
	end
endmodule
`default_nettype wire
